/* File: hdl/usb_err_defs.svh */
// Offsets, field positions, reset values and sizes for the USB error/status block
`ifndef USB_ERR_DEFS_SVH
`define USB_ERR_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_MAIN_IRQ_FLAGS   8'h00
`define OFS_MAIN_IRQ_ENABLE  8'h04
`define OFS_ERR_FLAGS        8'h08
`define OFS_ERR_IRQ_ENABLE   8'h0C
`define OFS_TRN_STATUS       8'h10
`define OFS_CONTROL          8'h14

// ==========================================================================
// Field positions
`define BIT_ERR_SUMMARY      1
`define BIT_ERR_MASTER_EN    1
`define BIT_TRN_DONE         3
`define BIT_HOST_MODE        0
`define STAT_EP_MSB          7
`define STAT_EP_LSB          4
`define STAT_DIR             3
`define STAT_BANK            2

// ==========================================================================
// Reset values and sizes
`define RST_ERR_IRQ_ENABLE   8'h00
`define RST_MAIN_IRQ_ENABLE  8'h00
`define TRN_FIFO_DEPTH       3'h4
`define NUM_ERR_FLAGS        8

`endif

/* File: hdl/usb_err_pkg.sv */
// Types shared by the USB error/status block
package usb_err_pkg;

	// ==========================================================================
	// One completed-transaction record
	typedef struct packed {
		logic [3:0] endpoint;
		logic       tx;
		logic       odd_bank;
	} trn_entry_t;

	// ==========================================================================
	// Register bus answer states
	typedef enum logic [0:0] {
		APB_IDLE,
		APB_ACK
	} apb_state_t;

endpackage

/* File: hdl/err_flag_bit.sv */
// One sticky error flag: hardware sets, software writes one to clear
`timescale 1ns/1ps
module err_flag_bit (
	input  wire logic i_ref_clk,
	input  wire logic i_arst_n,
	input  wire logic i_set,
	input  wire logic i_clear,
	output logic      o_flag
);
	// ==========================================================================
	// Set beats clear so an event in the clearing cycle is never lost
	wire next_flag = i_set | (o_flag & ~i_clear);

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_flag <= 1'b0;
		end else begin
			o_flag <= next_flag;
		end
	end
endmodule // err_flag_bit

/* File: hdl/trn_status_fifo.sv */
// Four-entry FIFO of completed-transaction records
`timescale 1ns/1ps
`include "usb_err_defs.svh"
module trn_status_fifo (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_arst_n,
	input  wire logic                    i_push,
	input  wire usb_err_pkg::trn_entry_t i_entry,
	input  wire logic                    i_pop,
	output usb_err_pkg::trn_entry_t      o_head,
	output logic [2:0]                   o_count,
	output logic [2:0]                   o_count_next,
	output logic                         o_push_ok
);
	// ==========================================================================
	// Storage and pointers
	usb_err_pkg::trn_entry_t mem [0:3];
	logic [1:0]              wr_ptr;
	logic [1:0]              rd_ptr;

	// Full refuses pushes; pop only when something is held
	wire pop_ok = i_pop & (o_count != 3'h0);
	assign o_push_ok    = i_push & (o_count != `TRN_FIFO_DEPTH);
	assign o_count_next = o_count + {2'h0, o_push_ok} - {2'h0, pop_ok};
	assign o_head       = mem[rd_ptr];

	// Pointers and count
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr  <= 2'h0;
			rd_ptr  <= 2'h0;
			o_count <= 3'h0;
		end else begin
			wr_ptr  <= wr_ptr + {1'b0, o_push_ok};
			rd_ptr  <= rd_ptr + {1'b0, pop_ok};
			o_count <= o_count_next;
		end
	end

	// Record write; contents need no reset, they are invalid while empty
	always_ff @(posedge i_ref_clk) begin
		if (o_push_ok) begin
			mem[wr_ptr] <= i_entry;
		end
	end
endmodule // trn_status_fifo

/* File: hdl/usb_err_status.sv */
// USB error interrupt enables and transaction status FIFO behind an APB slave
`timescale 1ns/1ps
`include "usb_err_defs.svh"

// Behaviour
// - Enable bit 7 gates bit-stuff error
// - Enable bit 6 gates bus matrix error
// - Enable bit 5 gates DMA error
// - Enable bit 4 gates turnaround timeout error
// - Enable bit 3 gates field size error
// - Enable bit 2 gates data CRC failure
// - Bit 1: token CRC device, EOF host
// - Enable bit 0 gates packet ID check
// - Bits 31 to 8 read zero
// - Error interrupt needs master enable bit 1
// - Status shows head of four-entry FIFO
// - Status valid only while done flag set
// - Clearing done flag advances the FIFO
// - Bits 7:4 hold endpoint number
// - Bit 3 one for transmit
// - Bit 2 one for odd bank
module usb_err_status (
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	input  wire logic [7:0]  i_err_event,
	input  wire logic        i_trn_push,
	input  wire logic [3:0]  i_trn_endpoint,
	input  wire logic        i_trn_tx,
	input  wire logic        i_trn_odd,
	output logic             o_trn_ready,
	output logic             o_usb_irq_flag,
	output logic             o_host_mode
);
	// ==========================================================================
	// State
	usb_err_pkg::apb_state_t state;
	usb_err_pkg::apb_state_t next_state;
	usb_err_pkg::trn_entry_t head;
	usb_err_pkg::trn_entry_t push_entry;
	logic [7:0]              err_enable;
	logic [7:0]              main_enable;
	logic [7:0]              err_flags;
	logic [2:0]              fifo_count;
	logic [2:0]              fifo_count_next;
	logic                    push_ok;

	// ==========================================================================
	// Bus decode
	wire access      = i_psel & i_penable;
	wire commit      = access & o_pready;
	wire wr_commit   = commit & i_pwrite;
	wire sel_flags   = (i_paddr == `OFS_MAIN_IRQ_FLAGS);
	wire sel_men     = (i_paddr == `OFS_MAIN_IRQ_ENABLE);
	wire sel_eflags  = (i_paddr == `OFS_ERR_FLAGS);
	wire sel_een     = (i_paddr == `OFS_ERR_IRQ_ENABLE);
	wire sel_stat    = (i_paddr == `OFS_TRN_STATUS);
	wire sel_ctrl    = (i_paddr == `OFS_CONTROL);
	wire mapped      = sel_flags | sel_men | sel_eflags | sel_een | sel_stat | sel_ctrl;
	wire wr_mapped   = wr_commit & mapped;

	// ==========================================================================
	// Interrupt gating
	wire [7:0] err_gated = err_flags & err_enable;
	// Bit 1 is one gate whose source the engine picks by mode
	wire err_hit  = |err_gated;
	wire trn_done = (fifo_count != 3'h0);
	wire next_irq = (err_hit & main_enable[`BIT_ERR_MASTER_EN])
		| (trn_done & main_enable[`BIT_TRN_DONE]);

	// Writing one to the done bit pops the head record
	wire pop = wr_commit & sel_flags & i_pwdata[`BIT_TRN_DONE];
	assign push_entry = '{endpoint: i_trn_endpoint, tx: i_trn_tx, odd_bank: i_trn_odd};

	// ==========================================================================
	// Read mux; narrow registers sit low, upper bits stay zero
	wire [7:0] rd_flags = {4'h0, trn_done, 1'b0, err_hit, 1'b0};
	wire [7:0] rd_stat  = {head.endpoint, head.tx, head.odd_bank, 2'h0};
	wire [7:0] rd_byte  =
		sel_flags  ? rd_flags :
		sel_men    ? main_enable :
		sel_eflags ? err_flags :
		sel_een    ? err_enable :
		sel_stat   ? rd_stat :
		sel_ctrl   ? {7'h00, o_host_mode} : 8'h00;
	wire [31:0] next_rdata = {24'h000000, rd_byte};

	// Answer one cycle into the access phase, then drop ready
	assign next_state = (state == usb_err_pkg::APB_IDLE && access) ?
		usb_err_pkg::APB_ACK : usb_err_pkg::APB_IDLE;
	// Data and error ride with ready only, so nothing stale lingers after the answer
	wire answer = (next_state == usb_err_pkg::APB_ACK);

	// ==========================================================================
	// Sticky error flags, one per source
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_ERR_FLAGS; gi = gi + 1) begin : g_err
			err_flag_bit u_flag (
				.i_ref_clk (i_ref_clk),
				.i_arst_n  (i_arst_n),
				.i_set     (i_err_event[gi]),
				.i_clear   (wr_commit & sel_eflags & i_pwdata[gi]),
				.o_flag    (err_flags[gi])
			);
		end
	endgenerate

	// Completed-transaction records
	trn_status_fifo u_fifo (
		.i_ref_clk    (i_ref_clk),
		.i_arst_n     (i_arst_n),
		.i_push       (i_trn_push),
		.i_entry      (push_entry),
		.i_pop        (pop),
		.o_head       (head),
		.o_count      (fifo_count),
		.o_count_next (fifo_count_next),
		.o_push_ok    (push_ok)
	);

	// ==========================================================================
	// Bus answer registers
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state     <= usb_err_pkg::APB_IDLE;
			o_pready  <= 1'b0;
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else begin
			state     <= next_state;
			o_pready  <= answer;
			o_prdata  <= (answer && !i_pwrite) ? next_rdata : 32'h00000000;
			o_pslverr <= answer & ~mapped;
		end
	end

	// Software writable registers
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			err_enable  <= `RST_ERR_IRQ_ENABLE;
			main_enable <= `RST_MAIN_IRQ_ENABLE;
			o_host_mode <= 1'b0;
		end else begin
			if (wr_mapped && sel_een) begin
				err_enable <= i_pwdata[7:0];
			end
			if (wr_mapped && sel_men) begin
				main_enable <= i_pwdata[7:0];
			end
			if (wr_mapped && sel_ctrl) begin
				o_host_mode <= i_pwdata[`BIT_HOST_MODE];
			end
		end
	end

	// Engine-facing outputs; ready tracks the next fill so a full FIFO stalls pushes
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_trn_ready    <= 1'b1;
			o_usb_irq_flag <= 1'b0;
		end else begin
			o_trn_ready    <= (fifo_count_next != `TRN_FIFO_DEPTH);
			o_usb_irq_flag <= next_irq;
		end
	end

	// ==========================================================================
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);

	stuff_gate_a: assert property (
		(err_flags[7] && err_enable[7] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("bit-stuff error enabled but no interrupt");

	stuff_block_a: assert property (
		(!err_enable[7] && (err_gated[6:0] == 7'h00) && !(trn_done && main_enable[3]))
		|=> !o_usb_irq_flag)
		else $error("disabled bit-stuff error raised the interrupt");

	mode_gate_a: assert property (
		(err_flags[1] && err_enable[1] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("bit 1 error did not propagate in current mode");

	master_off_a: assert property (
		(!main_enable[1] && !main_enable[3]) |=> !o_usb_irq_flag)
		else $error("interrupt raised without master enable");

	upper_zero_a: assert property (
		o_pready |-> (o_prdata[31:8] == 24'h000000))
		else $error("upper register bits not zero");

	head_fields_a: assert property (
		(push_ok && fifo_count == 3'h0) |=> (trn_done && head.endpoint == $past(i_trn_endpoint)
			&& head.tx == $past(i_trn_tx) && head.odd_bank == $past(i_trn_odd)))
		else $error("first record not shown at head");

	pop_adv_a: assert property (
		(pop && !push_ok && fifo_count != 3'h0) |=> (fifo_count == $past(fifo_count) - 3'h1))
		else $error("clearing done flag did not advance FIFO");

	full_stall_a: assert property (
		o_trn_ready == (fifo_count != `TRN_FIFO_DEPTH))
		else $error("ready disagrees with FIFO fill");

	ack_pulse_a: assert property (
		(access && state == usb_err_pkg::APB_IDLE) |=> o_pready ##1 !o_pready)
		else $error("bus answer not one cycle after access");

	done_valid_a: assert property (
		(fifo_count == 3'h1 && pop && !push_ok) |=> !trn_done)
		else $error("done flag stayed set on empty FIFO");

	// ==========================================================================
	// One gate check per remaining enable bit; a swapped bit trips one of them
	bmx_gate_a: assert property (
		(err_flags[6] && err_enable[6] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("bus matrix error enabled but no interrupt");

	dma_gate_a: assert property (
		(err_flags[5] && err_enable[5] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("DMA error enabled but no interrupt");

	tmo_gate_a: assert property (
		(err_flags[4] && err_enable[4] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("turnaround timeout error enabled but no interrupt");

	size_gate_a: assert property (
		(err_flags[3] && err_enable[3] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("field size error enabled but no interrupt");

	crc_gate_a: assert property (
		(err_flags[2] && err_enable[2] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("data CRC failure enabled but no interrupt");

	pid_gate_a: assert property (
		(err_flags[0] && err_enable[0] && main_enable[1]) |=> o_usb_irq_flag)
		else $error("packet ID check failure enabled but no interrupt");

	// Register writes land at the commit edge and nowhere else
	een_write_a: assert property (
		(wr_mapped && sel_een) |=> (err_enable == $past(i_pwdata[7:0])))
		else $error("error enable write did not land");

	men_write_a: assert property (
		(wr_mapped && sel_men) |=> (main_enable == $past(i_pwdata[7:0])))
		else $error("main enable write did not land");

	host_write_a: assert property (
		(wr_mapped && sel_ctrl) |=> (o_host_mode == $past(i_pwdata[`BIT_HOST_MODE])))
		else $error("host mode write did not land");

	// Sticky flags hold until cleared, and a fresh event beats a clear
	flag_hold_a: assert property (
		(err_flags[7] && !(wr_commit && sel_eflags && i_pwdata[7])) |=> err_flags[7])
		else $error("bit-stuff flag lost without a clear");

	set_wins_a: assert property (
		i_err_event[7] |=> err_flags[7])
		else $error("bit-stuff event not captured");

	// Bus answer shape
	slverr_ready_a: assert property (
		o_pslverr |-> o_pready)
		else $error("slave error shown without ready");

	rdata_idle_a: assert property (
		!o_pready |-> (o_prdata == 32'h00000000))
		else $error("read data shown without ready");

	// Status fields come from the head record seen in the access cycle
	wire stat_read = (state == usb_err_pkg::APB_IDLE) & access & ~i_pwrite & sel_stat;
	stat_ep_a: assert property (
		stat_read |=> (o_prdata[`STAT_EP_MSB:`STAT_EP_LSB] == $past(head.endpoint)))
		else $error("status endpoint field wrong");

	stat_dir_a: assert property (
		stat_read |=> (o_prdata[`STAT_DIR] == $past(head.tx)))
		else $error("status direction bit wrong");

	stat_bank_a: assert property (
		stat_read |=> (o_prdata[`STAT_BANK] == $past(head.odd_bank)))
		else $error("status bank bit wrong");

	// FIFO depth, refusal when full, and the done interrupt
	count_max_a: assert property (
		fifo_count <= `TRN_FIFO_DEPTH)
		else $error("FIFO fill beyond four entries");

	push_full_a: assert property (
		(i_trn_push && fifo_count == `TRN_FIFO_DEPTH && !pop) |=> (fifo_count == `TRN_FIFO_DEPTH))
		else $error("push taken while FIFO full");

	irq_done_a: assert property (
		(trn_done && main_enable[`BIT_TRN_DONE]) |=> o_usb_irq_flag)
		else $error("done flag enabled but no interrupt");

	fill_c: cover property (fifo_count == `TRN_FIFO_DEPTH ##1 pop);
	irq_c: cover property (!o_usb_irq_flag ##1 o_usb_irq_flag);
	unmapped_c: cover property (o_pready && o_pslverr);
	push_pop_c: cover property (push_ok && pop);
	stall_c: cover property (i_trn_push && !o_trn_ready);

endmodule // usb_err_status

/* File: verification/usb_engine_model.sv */
// Behavioural USB engine that pushes completed-transaction records
`timescale 1ns/1ps
module usb_engine_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_arst_n,
	input  wire logic [3:0] i_total,
	input  wire logic       i_trn_ready,
	output logic            o_trn_push,
	output logic [3:0]      o_trn_endpoint,
	output logic            o_trn_tx,
	output logic            o_trn_odd
);
	logic [3:0] sent;

	// ==========================================================================
	// Record k: endpoint k*15 mod 16, direction k bit 0, bank k bit 1
	// Outside a push the fields show the inverse, so stale values are never trusted
	assign o_trn_push     = (sent != i_total);
	assign o_trn_endpoint = o_trn_push ? sent * 4'hF : ~sent;
	assign o_trn_tx       = o_trn_push ? sent[0] : ~sent[0];
	assign o_trn_odd      = o_trn_push ? sent[1] : ~sent[1];

	// One record per completion; the push is held while the FIFO is full
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sent <= 4'h0;
		end else if (o_trn_push && i_trn_ready) begin
			sent <= sent + 4'h1;
		end
	end
endmodule // usb_engine_model

/* File: verification/usb_error_enable_and_status_fifo_tb_top.sv */
// Self-checking bench for the USB error enable and status FIFO block
`timescale 1ns/1ps
`include "usb_err_defs.svh"
module usb_error_enable_and_status_fifo_tb_top;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic        push, tx, odd, trn_ready, irq, host;
	logic [7:0]  paddr, err_ev;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  ep, total;
	logic        rd_err;
	int          failures, compares;

	usb_err_status dut_u (.i_ref_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_err_event(err_ev),
		.i_trn_push(push), .i_trn_endpoint(ep), .i_trn_tx(tx), .i_trn_odd(odd),
		.o_trn_ready(trn_ready), .o_usb_irq_flag(irq), .o_host_mode(host));

	usb_engine_model eng_u (.i_ref_clk(clk), .i_arst_n(arst_n), .i_total(total),
		.i_trn_ready(trn_ready), .o_trn_push(push), .o_trn_endpoint(ep),
		.o_trn_tx(tx), .o_trn_odd(odd));

	// ==========================================================================
	// Shared tasks
	task automatic close_out();
		if (failures == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// APB transfer; waits for ready with no assumed latency
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle error event, then time for flag and interrupt to settle
	task automatic fire(input int b);
		@(posedge clk);
		err_ev <= 8'h01 << b;
		@(posedge clk);
		err_ev <= 8'h00;
		repeat (3) @(posedge clk);
	endtask

	// ==========================================================================
	// Clock, watchdog and test sequence
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end

	initial begin
		arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; err_ev = 8'h00; total = 4'h0; failures = 0; compares = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, `OFS_ERR_IRQ_ENABLE, 32'h0);
		chk("err_en_reset", rd, 32'h0);
		apb(1'b1, `OFS_ERR_IRQ_ENABLE, 32'hFFFFFFFF);
		apb(1'b0, `OFS_ERR_IRQ_ENABLE, 32'h0);
		chk("err_en_upper", rd, 32'h000000FF);
		apb(1'b0, 8'hFC, 32'h0);
		chk("unmapped_err", 32'(rd_err), 32'h1);
		// Master enable off keeps the enabled packet ID error (bit 0) away from the interrupt
		fire(0);
		chk("irq_no_master", 32'(irq), 32'h0);
		apb(1'b1, `OFS_MAIN_IRQ_ENABLE, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq_master", 32'(irq), 32'h1);
		// Each enable bit alone, in device and host mode
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, `OFS_CONTROL, 32'(m));
			// The mode flop updates at the commit edge; look one cycle later
			@(posedge clk);
			chk("host_mode", 32'(host), 32'(m));
			for (int b = 0; b < 8; b++) begin
				apb(1'b1, `OFS_ERR_FLAGS, 32'hFF);
				apb(1'b1, `OFS_ERR_IRQ_ENABLE, 32'(~(8'h01 << b)));
				fire(b);
				chk("gate_off", 32'(irq), 32'h0);
				apb(1'b1, `OFS_ERR_IRQ_ENABLE, 32'(8'h01 << b));
				repeat (2) @(posedge clk);
				chk("gate_on", 32'(irq), 32'h1);
			end
		end
		// Five completions into a four-entry FIFO, then drain in order
		total <= 4'h5;
		repeat (12) @(posedge clk);
		chk("full_stall", 32'(trn_ready), 32'h0);
		// Error master off, done enable on: only the held records may interrupt
		apb(1'b1, `OFS_MAIN_IRQ_ENABLE, 32'h8);
		repeat (2) @(posedge clk);
		chk("irq_done", 32'(irq), 32'h1);
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, `OFS_MAIN_IRQ_FLAGS, 32'h0);
			chk("done_flag", 32'(rd[`BIT_TRN_DONE]), 32'h1);
			apb(1'b0, `OFS_TRN_STATUS, 32'h0);
			chk("status", rd, {24'h0, 4'(k * 15), k[0], k[1], 2'b00});
			apb(1'b1, `OFS_MAIN_IRQ_FLAGS, 32'h8);
		end
		apb(1'b0, `OFS_MAIN_IRQ_FLAGS, 32'h0);
		chk("done_empty", 32'(rd[`BIT_TRN_DONE]), 32'h0);
		chk("ready_again", 32'(trn_ready), 32'h1);
		chk("irq_drained", 32'(irq), 32'h0);
		close_out();
	end
endmodule // usb_error_enable_and_status_fifo_tb_top
